// [verilog/ulin_uart.sv]
// How it works
// R1 - timeout raw flag needs its mask bit set
// R2 - software polls via mask, core line disabled
// R3 - instances use interrupt lines 21, 22, 49
// R4 - nominal break is thirteen plus code bits
// R5 - sent break is one bit shorter
// R6 - software programs code one higher
// R7 - no burst requests in lin or infrared
// R8 - dma channel must accept single requests
// R9 - flag driven transfers need fast clock
// R10 - dma transfers work at any rate
// R11 - break settings sampled at header start
module ulin_uart #(
  parameter int INSTANCE = 0,
  parameter bit SILICON_FIXED = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rxd,
  output logic txd,
  // dma requests
  output logic dma_rx_single,
  output logic dma_rx_burst,
  output logic dma_tx_single,
  output logic dma_tx_burst,
  // interrupt
  output logic irq
);
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} ulin_rx_state_t;

  ulin_tx_if tx ();

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [15:0] div_q, div_d;
  logic [1:0] break_length_code_q, break_length_code_d;
  logic lin_en_q, lin_en_d;
  logic sir_en_q, sir_en_d;
  logic [3:0] dma_q, dma_d;
  logic [ulin_pkg::NUM_IRQ-1:0] raw_q, raw_d;
  logic [ulin_pkg::NUM_IRQ-1:0] mask_q, mask_d;
  logic irq_q, irq_d;
  logic [7:0] tx_hold_q, tx_hold_d;
  logic tx_full_q, tx_full_d;
  logic hdr_req_q, hdr_req_d;
  logic [4:0] hdr_bits_q, hdr_bits_d;
  logic hdr_mode_q, hdr_mode_d;
  logic rx_sr_q, rx_sr_d;
  logic rx_st_q, rx_st_d;
  logic tx_sr_q, tx_sr_d;
  logic tx_st_q, tx_st_d;

  // ---------------------------------------------------------------
  // receive state
  // ---------------------------------------------------------------
  ulin_rx_state_t rx_state_q, rx_state_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bits_q, rx_bits_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic [7:0] rx_hold_q, rx_hold_d;
  logic rx_full_q, rx_full_d;
  logic rx_done_q, rx_done_d;
  logic [15:0] rt_cnt_q, rt_cnt_d;
  logic [5:0] rt_bits_q, rt_bits_d;
  logic rt_event_q, rt_event_d;

  logic access;
  logic wr;
  logic rd;
  logic rx_pop;
  logic [ulin_pkg::NUM_IRQ-1:0] events;
  logic [ulin_pkg::NUM_IRQ-1:0] w1c;
  logic [4:0] brk_base;
  logic burst_blocked;

  assign access = psel & penable & pready_q;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign rx_pop = rd & (paddr == ulin_pkg::OFS_DATA);
  assign brk_base = SILICON_FIXED ? ulin_pkg::BRK_BASE_SPEC : ulin_pkg::BRK_BASE_ACTUAL; // [R4] [R5]
  assign burst_blocked = lin_en_q | sir_en_q; // [R7]

  assign events[ulin_pkg::IRQ_RX] = rx_done_q;
  assign events[ulin_pkg::IRQ_TX] = tx.byte_taken;
  // on affected parts the timeout only records while its mask bit is on
  assign events[ulin_pkg::IRQ_RT] = rt_event_q & (SILICON_FIXED | mask_q[ulin_pkg::IRQ_RT]); // [R1] [R2]
  assign events[ulin_pkg::IRQ_BRK] = tx.break_done;
  assign w1c = (wr && paddr == ulin_pkg::OFS_RAW_IRQ) ? pwdata[ulin_pkg::NUM_IRQ-1:0] : '0;

  assign tx.start_byte = tx_full_q;
  assign tx.start_break = hdr_req_q & hdr_mode_q; // [R11]
  assign tx.byte_data = tx_hold_q;
  assign tx.break_bits = hdr_bits_q;
  assign tx.divisor = div_q;

  ulin_tx_engine u_tx (
    .clock (clock),
    .rst_n (rst_n),
    .tx (tx.eng)
  );

  // ---------------------------------------------------------------
  // bus, registers, interrupt and dma
  // ---------------------------------------------------------------
  always_comb
  begin
    pready_d = psel & penable & ~pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    div_d = div_q;
    break_length_code_d = break_length_code_q;
    lin_en_d = lin_en_q;
    sir_en_d = sir_en_q;
    dma_d = dma_q;
    mask_d = mask_q;
    tx_hold_d = tx_hold_q;
    tx_full_d = tx_full_q & ~tx.byte_taken;
    hdr_req_d = hdr_req_q & ~tx.busy;
    hdr_bits_d = hdr_bits_q;
    hdr_mode_d = hdr_mode_q;
    if (psel && penable && !pready_q)
    begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        ulin_pkg::OFS_DATA: prdata_d[7:0] = rx_hold_q;
        ulin_pkg::OFS_STATUS:
        begin
          prdata_d[ulin_pkg::ST_TX_BUSY] = tx.busy;
          prdata_d[ulin_pkg::ST_RX_FULL] = rx_full_q;
          prdata_d[ulin_pkg::ST_TX_FULL] = tx_full_q;
        end
        ulin_pkg::OFS_DIVISOR: prdata_d[15:0] = div_q;
        ulin_pkg::OFS_LIN_CTRL:
        begin
          prdata_d[ulin_pkg::LC_BREAK_LENGTH_CODE_LSB +: 2] = break_length_code_q;
          prdata_d[ulin_pkg::LC_LIN_EN] = lin_en_q;
          prdata_d[ulin_pkg::LC_SIR_EN] = sir_en_q;
        end
        ulin_pkg::OFS_RAW_IRQ: prdata_d[ulin_pkg::NUM_IRQ-1:0] = raw_q;
        ulin_pkg::OFS_IRQ_MASK: prdata_d[ulin_pkg::NUM_IRQ-1:0] = mask_q;
        ulin_pkg::OFS_DMA_CTRL: prdata_d[3:0] = dma_q;
        ulin_pkg::OFS_INFO: prdata_d[5:0] = ulin_pkg::IRQ_LINE[INSTANCE]; // [R3]
        default: pslverr_d = 1'b1;
      endcase
    end
    if (wr)
    begin
      unique case (paddr)
        ulin_pkg::OFS_DATA:
          // a byte written while the holding slot is full is dropped
          if (!tx_full_q)
          begin
            tx_hold_d = pwdata[7:0];
            tx_full_d = 1'b1;
          end
        ulin_pkg::OFS_DIVISOR: div_d = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        ulin_pkg::OFS_LIN_CTRL:
        begin
          break_length_code_d = pwdata[ulin_pkg::LC_BREAK_LENGTH_CODE_LSB +: 2];
          lin_en_d = pwdata[ulin_pkg::LC_LIN_EN];
          sir_en_d = pwdata[ulin_pkg::LC_SIR_EN];
          // settings are frozen here; later writes do not touch a running break
          if (pwdata[ulin_pkg::LC_SEND_HDR] && pwdata[ulin_pkg::LC_LIN_EN] && !hdr_req_q)
          begin
            hdr_req_d = 1'b1;
            hdr_bits_d = brk_base + {3'h0, pwdata[ulin_pkg::LC_BREAK_LENGTH_CODE_LSB +: 2]}; // [R11] [R5] [R6]
            hdr_mode_d = pwdata[ulin_pkg::LC_LIN_EN]; // [R11]
          end
        end
        ulin_pkg::OFS_IRQ_MASK: mask_d = pwdata[ulin_pkg::NUM_IRQ-1:0];
        ulin_pkg::OFS_DMA_CTRL: dma_d = pwdata[3:0];
        default: ;
      endcase
    end
    // a new event outweighs a clear landing in the same cycle
    raw_d = (raw_q & ~w1c) | events;
    irq_d = |(raw_d & mask_d);
    rx_sr_d = dma_q[ulin_pkg::DMA_RX_EN] & rx_full_d & ~(burst_blocked & dma_q[ulin_pkg::DMA_RX_BURST_ONLY]); // [R7] [R8]
    rx_st_d = dma_q[ulin_pkg::DMA_RX_EN] & rx_full_d & ~burst_blocked; // [R7] [R10]
    tx_sr_d = dma_q[ulin_pkg::DMA_TX_EN] & ~tx_full_d & ~(burst_blocked & dma_q[ulin_pkg::DMA_TX_BURST_ONLY]); // [R7] [R8]
    tx_st_d = dma_q[ulin_pkg::DMA_TX_EN] & ~tx_full_d & ~burst_blocked; // [R7] [R10]
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      div_q <= ulin_pkg::DIVISOR_RESET;
      break_length_code_q <= 2'h0;
      lin_en_q <= 1'b0;
      sir_en_q <= 1'b0;
      dma_q <= 4'h0;
      raw_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
      hdr_req_q <= 1'b0;
      hdr_bits_q <= 5'h00;
      hdr_mode_q <= 1'b0;
      rx_sr_q <= 1'b0;
      rx_st_q <= 1'b0;
      tx_sr_q <= 1'b0;
      tx_st_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      div_q <= div_d;
      break_length_code_q <= break_length_code_d;
      lin_en_q <= lin_en_d;
      sir_en_q <= sir_en_d;
      dma_q <= dma_d;
      raw_q <= raw_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      tx_hold_q <= tx_hold_d;
      tx_full_q <= tx_full_d;
      hdr_req_q <= hdr_req_d;
      hdr_bits_q <= hdr_bits_d;
      hdr_mode_q <= hdr_mode_d;
      rx_sr_q <= rx_sr_d;
      rx_st_q <= rx_st_d;
      tx_sr_q <= tx_sr_d;
      tx_st_q <= tx_st_d;
    end
  end

  // ---------------------------------------------------------------
  // receiver and receive timeout
  // ---------------------------------------------------------------
  always_comb
  begin
    rx_state_d = rx_state_q;
    rx_cnt_d = rx_cnt_q + 16'h0001;
    rx_bits_d = rx_bits_q;
    rx_sh_d = rx_sh_q;
    rx_hold_d = rx_hold_q;
    rx_full_d = rx_full_q & ~rx_pop;
    rx_done_d = 1'b0;
    rt_cnt_d = rt_cnt_q;
    rt_bits_d = rt_bits_q;
    rt_event_d = 1'b0;
    unique case (rx_state_q)
      R_IDLE:
      begin
        rx_cnt_d = 16'h0000;
        if (!rxd)
        begin
          rx_state_d = R_START;
        end
      end
      R_START:
        // a glitch shorter than half a bit is not a start bit
        if (rx_cnt_q >= {1'b0, div_q[15:1]})
        begin
          rx_cnt_d = 16'h0000;
          rx_bits_d = 4'h0;
          rx_state_d = rxd ? R_IDLE : R_DATA;
        end
      R_DATA:
        if (rx_cnt_q >= div_q - 16'h0001)
        begin
          rx_cnt_d = 16'h0000;
          rx_sh_d = {rxd, rx_sh_q[7:1]};
          rx_bits_d = rx_bits_q + 4'h1;
          if (rx_bits_q == ulin_pkg::DATA_BITS - 4'h1)
          begin
            rx_state_d = R_STOP;
          end
        end
      R_STOP:
        if (rx_cnt_q >= div_q - 16'h0001)
        begin
          rx_state_d = R_IDLE;
          // a byte arriving while the slot is still full overwrites it
          rx_hold_d = rx_sh_q;
          rx_full_d = 1'b1;
          rx_done_d = 1'b1;
        end
    endcase
    // timeout: a held byte with a quiet line for a fixed number of bit times
    if (!rx_full_q || rx_state_q != R_IDLE || rx_pop)
    begin
      rt_cnt_d = 16'h0000;
      rt_bits_d = 6'h00;
    end
    else if (rt_bits_q != ulin_pkg::RT_BITS)
    begin
      rt_cnt_d = rt_cnt_q + 16'h0001;
      if (rt_cnt_q >= div_q - 16'h0001)
      begin
        rt_cnt_d = 16'h0000;
        rt_bits_d = rt_bits_q + 6'h01;
        rt_event_d = (rt_bits_q == ulin_pkg::RT_BITS - 6'h01);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_q <= R_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_bits_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_hold_q <= 8'h00;
      rx_full_q <= 1'b0;
      rx_done_q <= 1'b0;
      rt_cnt_q <= 16'h0000;
      rt_bits_q <= 6'h00;
      rt_event_q <= 1'b0;
    end
    else
    begin
      rx_state_q <= rx_state_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bits_q <= rx_bits_d;
      rx_sh_q <= rx_sh_d;
      rx_hold_q <= rx_hold_d;
      rx_full_q <= rx_full_d;
      rx_done_q <= rx_done_d;
      rt_cnt_q <= rt_cnt_d;
      rt_bits_q <= rt_bits_d;
      rt_event_q <= rt_event_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txd = tx.txd;
  assign irq = irq_q;
  assign dma_rx_single = rx_sr_q;
  assign dma_rx_burst = rx_st_q;
  assign dma_tx_single = tx_sr_q;
  assign dma_tx_burst = tx_st_q;
endmodule // ulin_uart

// [shared/ulin_pkg.sv]
package ulin_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIVISOR = 8'h08;
  localparam logic [7:0] OFS_LIN_CTRL = 8'h0c;
  localparam logic [7:0] OFS_RAW_IRQ = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_DMA_CTRL = 8'h18;
  localparam logic [7:0] OFS_INFO = 8'h1c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_TX_FULL = 2;
  localparam int LC_BREAK_LENGTH_CODE_LSB = 0;
  localparam int LC_LIN_EN = 4;
  localparam int LC_SIR_EN = 5;
  localparam int LC_SEND_HDR = 8;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_RT = 2;
  localparam int IRQ_BRK = 3;
  localparam int NUM_IRQ = 4;
  localparam int DMA_RX_EN = 0;
  localparam int DMA_TX_EN = 1;
  localparam int DMA_RX_BURST_ONLY = 2;
  localparam int DMA_TX_BURST_ONLY = 3;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] DIVISOR_RESET = 16'h0364;
  localparam logic [4:0] BRK_BASE_SPEC = 5'h0d;
  localparam logic [4:0] BRK_BASE_ACTUAL = 5'h0c;
  localparam logic [5:0] RT_BITS = 6'h20;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [5:0] IRQ_LINE [3] = '{6'h15, 6'h16, 6'h31};
endpackage : ulin_pkg

// [shared/ulin_tx_if.sv]
interface ulin_tx_if;
  logic start_byte;
  logic start_break;
  logic [7:0] byte_data;
  logic [4:0] break_bits;
  logic [15:0] divisor;
  logic busy;
  logic byte_taken;
  logic break_done;
  logic txd;

  modport ctl (
    output start_byte, start_break, byte_data, break_bits, divisor,
    input busy, byte_taken, break_done, txd
  );
  modport eng (
    input start_byte, start_break, byte_data, break_bits, divisor,
    output busy, byte_taken, break_done, txd
  );
endinterface : ulin_tx_if

// [verilog/ulin_tx_engine.sv]
module ulin_tx_engine (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control side
  ulin_tx_if.eng tx
);
  typedef enum logic [2:0] {E_IDLE, E_BREAK, E_DELIM, E_START, E_DATA, E_STOP} ulin_tx_state_t;

  ulin_tx_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [4:0] bits_q, bits_d;
  logic [7:0] sh_q, sh_d;
  logic txd_q, txd_d;
  logic taken_q, taken_d;
  logic done_q, done_d;
  logic tick;

  assign tick = (cnt_q >= tx.divisor - 16'h0001);
  assign tx.busy = (state_q != E_IDLE);
  assign tx.byte_taken = taken_q;
  assign tx.break_done = done_q;
  assign tx.txd = txd_q;

  always_comb
  begin
    state_d = state_q;
    cnt_d = tick ? 16'h0000 : cnt_q + 16'h0001;
    bits_d = bits_q;
    sh_d = sh_q;
    txd_d = txd_q;
    taken_d = 1'b0;
    done_d = 1'b0;
    unique case (state_q)
      E_IDLE:
      begin
        cnt_d = 16'h0000;
        txd_d = 1'b1;
        // a header request wins over a waiting byte so the break leads
        if (tx.start_break)
        begin
          state_d = E_BREAK;
          bits_d = tx.break_bits;
          txd_d = 1'b0;
        end
        else if (tx.start_byte)
        begin
          state_d = E_START;
          sh_d = tx.byte_data;
          txd_d = 1'b0;
          taken_d = 1'b1;
        end
      end
      E_BREAK:
        if (tick)
        begin
          bits_d = bits_q - 5'h01;
          if (bits_q == 5'h01)
          begin
            state_d = E_DELIM;
            txd_d = 1'b1;
          end
        end
      E_DELIM:
        if (tick)
        begin
          state_d = E_IDLE;
          done_d = 1'b1;
        end
      E_START:
        if (tick)
        begin
          state_d = E_DATA;
          txd_d = sh_q[0];
          bits_d = {1'b0, ulin_pkg::DATA_BITS};
        end
      E_DATA:
        if (tick)
        begin
          if (bits_q == 5'h01)
          begin
            state_d = E_STOP;
            txd_d = 1'b1;
          end
          else
          begin
            sh_d = {1'b0, sh_q[7:1]};
            txd_d = sh_q[1];
            bits_d = bits_q - 5'h01;
          end
        end
      E_STOP:
        if (tick)
        begin
          state_d = E_IDLE;
        end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= E_IDLE;
      cnt_q <= 16'h0000;
      bits_q <= 5'h00;
      sh_q <= 8'h00;
      txd_q <= 1'b1;
      taken_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      txd_q <= txd_d;
      taken_q <= taken_d;
      done_q <= done_d;
    end
  end
endmodule // ulin_tx_engine

// [test/ulin_line_model.sv]
module ulin_line_model #(
  parameter int DIV = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // serial line
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_run = 0;
  int last_run = 0;

  initial rxd = 1'b1;

  // ---------------------------------------------------------------
  // length of the latest low stretch on the line, in clock cycles
  // ---------------------------------------------------------------
  always @(posedge clock)
  begin
    if (txd === 1'b0 && rst_n)
      low_run <= low_run + 1;
    else
    begin
      if (low_run != 0)
        last_run <= low_run;
      low_run <= 0;
    end
  end

  // one frame: start, eight data bits lsb first, stop; line idles high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (DIV) @(posedge clock);
    end
  endtask

  // samples mid-bit, so a frame must already be on its way or coming
  task automatic get_byte(output logic [7:0] b);
    while (txd !== 1'b0)
      @(posedge clock);
    repeat (DIV / 2) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (DIV) @(posedge clock);
      b[i] = txd;
    end
    // end mid stop bit, so a low last data bit is never taken for the next start
    repeat (DIV) @(posedge clock);
  endtask
endmodule // ulin_line_model

// [test/ulin_uart_checker.sv]
module ulin_uart_checker #(
  parameter int INSTANCE = 0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line, dma and interrupt
  input wire logic rxd,
  input wire logic txd,
  input wire logic dma_rx_single,
  input wire logic dma_rx_burst,
  input wire logic dma_tx_single,
  input wire logic dma_tx_burst,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // shadow of the settings the checks depend on
  // ---------------------------------------------------------------
  logic wr_hit, lin_sir, gate_rx;
  logic [15:0] div_q, div_d;
  logic [5:0] lc_q, lc_d;
  logic [3:0] dma_q, dma_d, mask_q, mask_d;
  logic [31:0] low_q, low_d;
  assign wr_hit = psel && penable && pready && pwrite;
  assign lin_sir = lc_q[ulin_pkg::LC_LIN_EN] | lc_q[ulin_pkg::LC_SIR_EN];
  assign gate_rx = lin_sir & dma_q[ulin_pkg::DMA_RX_BURST_ONLY];

  always_comb
  begin
    div_d = div_q;
    lc_d = lc_q;
    dma_d = dma_q;
    mask_d = mask_q;
    if (wr_hit && paddr == ulin_pkg::OFS_DIVISOR)
      div_d = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    if (wr_hit && paddr == ulin_pkg::OFS_LIN_CTRL)
      lc_d = pwdata[5:0];
    if (wr_hit && paddr == ulin_pkg::OFS_DMA_CTRL)
      dma_d = pwdata[3:0];
    if (wr_hit && paddr == ulin_pkg::OFS_IRQ_MASK)
      mask_d = pwdata[3:0];
    low_d = txd ? 32'h0 : low_q + 32'h1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= ulin_pkg::DIVISOR_RESET;
      lc_q <= 6'h00;
      dma_q <= 4'h0;
      mask_q <= 4'h0;
      low_q <= 32'h0;
    end
    else
    begin
      div_q <= div_d;
      lc_q <= lc_d;
      dma_q <= dma_d;
      mask_q <= mask_d;
      low_q <= low_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_APB_ONE_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb answer not in second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_DECODE: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h1c))
    else $error("pslverr does not match address map");
  AST_ERR_RDATA: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  AST_INFO_LINE: assert property (pready && !pwrite && paddr == ulin_pkg::OFS_INFO |->
    prdata == {26'h0, ulin_pkg::IRQ_LINE[INSTANCE]}) else $error("wrong interrupt line number");
  AST_NO_BURST_LIN: assert property (lin_sir && $past(lin_sir) |-> !dma_rx_burst && !dma_tx_burst)
    else $error("burst request in lin or infrared mode");
  AST_RX_GATED: assert property (gate_rx && $past(gate_rx) |-> !dma_rx_single)
    else $error("rx request with burst only in lin or infrared mode");
  AST_BURST_HAS_SINGLE: assert property (dma_tx_burst |-> dma_tx_single)
    else $error("tx burst request without single request");
  AST_IRQ_MASKED: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
    else $error("irq raised with every source masked");
  AST_BREAK_MAX: assert property (!txd |-> low_q < 32'd15 * div_q)
    else $error("line held low beyond shortened break");

  cover property (pslverr);
  cover property (irq);
  cover property (lin_sir && dma_tx_single);
  cover property ($rose(txd) && low_q > 32'd12 * div_q);
endmodule // ulin_uart_checker

bind ulin_uart ulin_uart_checker #(.INSTANCE(INSTANCE)) ulin_uart_checker_inst (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .txd(txd), .dma_rx_single(dma_rx_single), .dma_rx_burst(dma_rx_burst),
  .dma_tx_single(dma_tx_single), .dma_tx_burst(dma_tx_burst), .irq(irq)
);

// [test/uart_lin_status_dma_behaviour_tb.sv]
module uart_lin_status_dma_behaviour_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 16;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, rxd, txd, irq;
  logic dma_rx_single, dma_rx_burst, dma_tx_single, dma_tx_burst, err;
  logic [7:0] paddr, b, got;
  logic [31:0] pwdata, prdata, rd;
  int fail_count = 0;
  int cmp_count = 0;
  int seed;

  ulin_uart ulin_uart_inst (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .dma_rx_single(dma_rx_single), .dma_rx_burst(dma_rx_burst),
    .dma_tx_single(dma_tx_single), .dma_tx_burst(dma_tx_burst), .irq(irq)
  );
  ulin_line_model #(.DIV(DIV)) ulin_line_model_inst (.clock(clock), .rst_n(rst_n), .txd(txd), .rxd(rxd));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock; // well above the clock floor for flag driven transfers
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; holds the request until pready is seen
  // one idle cycle at the end so two calls never drive psel twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // sent break is one bit time shorter than the nominal table
  function automatic logic [31:0] brk_cycles(input int code);
    brk_cycles = 32'((int'(ulin_pkg::BRK_BASE_SPEC) + code - 1) * DIV);
  endfunction

  // {burst, single} of an enabled channel that has work pending
  function automatic logic [1:0] dma_exp(input logic bo, input logic ls);
    dma_exp = {~ls, ~(bo & ls)};
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clock);
    fail_count++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    seed = 83;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, ulin_pkg::OFS_DIVISOR, 32'h0);
    chk(rd, 32'(ulin_pkg::DIVISOR_RESET));
    apb(1'b0, ulin_pkg::OFS_INFO, 32'h0);
    chk(rd, 32'(ulin_pkg::IRQ_LINE[0]));
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, ulin_pkg::OFS_DIVISOR, DIV);
    $display("test registers done");
    // timeout flag with its mask clear, then set for polling
    ulin_line_model_inst.send_byte(8'($random(seed)));
    repeat (40 * DIV) @(posedge clock);
    apb(1'b0, ulin_pkg::OFS_RAW_IRQ, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, ulin_pkg::OFS_IRQ_MASK, 32'h4);
    apb(1'b1, ulin_pkg::OFS_RAW_IRQ, 32'hf);
    ulin_line_model_inst.send_byte(8'h00);
    repeat (40 * DIV) @(posedge clock);
    apb(1'b0, ulin_pkg::OFS_RAW_IRQ, 32'h0);
    chk(rd, 32'h5);
    chk(irq, 1'b1);
    apb(1'b0, ulin_pkg::OFS_DATA, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ulin_pkg::OFS_RAW_IRQ, 32'hf);
    apb(1'b1, ulin_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    $display("test rx timeout done");
    for (int i = 0; i < 3; i++)
    begin
      b = (i == 0) ? 8'h80 : 8'($random(seed));
      apb(1'b1, ulin_pkg::OFS_DATA, {24'h0, b});
      ulin_line_model_inst.get_byte(got);
      chk(got, b);
    end
    repeat (3 * DIV) @(posedge clock);
    apb(1'b0, ulin_pkg::OFS_RAW_IRQ, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, ulin_pkg::OFS_RAW_IRQ, 32'hf);
    $display("test tx done");
    // every break code; each sent break is one bit time shorter than its code's nominal length
    for (int code = 0; code < 4; code++)
    begin
      apb(1'b1, ulin_pkg::OFS_LIN_CTRL, 32'h110 | code);
      apb(1'b1, ulin_pkg::OFS_LIN_CTRL, 32'h010 | (3 - code));
      rd = 32'h0;
      while (rd[3] !== 1'b1)
        apb(1'b0, ulin_pkg::OFS_RAW_IRQ, 32'h0);
      chk(ulin_line_model_inst.last_run, brk_cycles(code));
      apb(1'b1, ulin_pkg::OFS_RAW_IRQ, 32'h8);
    end
    $display("test break done");
    // a held rx byte and the empty tx slot give both channels work; no mode, lin, infrared; burst-only set and cleared
    ulin_line_model_inst.send_byte(8'($random(seed)));
    for (int m = 0; m < 3; m++)
      for (int bo = 0; bo < 2; bo++)
      begin
        apb(1'b1, ulin_pkg::OFS_LIN_CTRL, (m == 0) ? 32'h0 : 32'h1 << (3 + m));
        apb(1'b1, ulin_pkg::OFS_DMA_CTRL, (bo == 1) ? 32'hf : 32'h3);
        repeat (3) @(posedge clock);
        chk({dma_rx_burst, dma_rx_single, dma_tx_burst, dma_tx_single}, {2{dma_exp(1'(bo), m != 0)}});
      end
    $display("test dma done");
    stop_test();
  end
endmodule // uart_lin_status_dma_behaviour_tb
